/* src/target_pkg.sv */
// Constants and carrier types for the trip target indicator latch
package target_pkg;

	// Timing
	localparam int unsigned CLK_PERIOD_NS        = 100;
	localparam int unsigned PROC_INTERVAL_US     = 4167;
	localparam int unsigned INTERVAL_CYCLES_DFLT =
		(PROC_INTERVAL_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned INTERVALS_PER_CYCLE  = 4;
	localparam int unsigned FAULT_INSTANTANEOUS_TRIP_LAMP_CYCLES    = 3;
	localparam int unsigned FAULT_INSTANTANEOUS_TRIP_LAMP_INTERVALS =
		FAULT_INSTANTANEOUS_TRIP_LAMP_CYCLES * INTERVALS_PER_CYCLE;
	localparam int unsigned LAMP_TEST_MS         = 1000;
	localparam int unsigned LAMP_TEST_INTERVALS  =
		(LAMP_TEST_MS * 1000 + PROC_INTERVAL_US - 1) / PROC_INTERVAL_US;
	localparam int unsigned FAULT_AGE_W          = 4;
	localparam int unsigned LAMP_CNT_W           = 8;

	// Lamp positions
	localparam int unsigned LAMP_COUNT   = 16;
	localparam int unsigned LAMP_ENABLED = 0;
	localparam int unsigned LAMP_TRIP    = 1;
	localparam int unsigned LAMP_INSTANTANEOUS_TRIP_LAMP    = 2;
	localparam int unsigned LAMP_ASSIST  = 3;
	localparam int unsigned LAMP_SWITCH  = 4;
	localparam int unsigned LAMP_DEFTIME = 5;
	localparam int unsigned LAMP_TIMEOC  = 6;
	localparam int unsigned LAMP_FREQ    = 7;
	localparam int unsigned LAMP_PHASE_A = 8;
	localparam int unsigned LAMP_RESID   = 11;
	localparam int unsigned LAMP_NEUT    = 12;
	localparam int unsigned LAMP_RS      = 13;
	localparam int unsigned LAMP_CY      = 14;
	localparam int unsigned LAMP_LO      = 15;

	// APB register map
	localparam logic [7:0] CONFIG_OFS = 8'h00;
	localparam logic [7:0] CMD_OFS    = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam int unsigned CFG_RECL_EN    = 0;
	localparam int unsigned CFG_LOW_RATING = 1;
	localparam int unsigned CFG_COMP_DIR   = 2;
	localparam int unsigned CFG_OI_LSB     = 8;
	localparam int unsigned CMD_CLEAR      = 0;
	localparam int unsigned STAT_FAULT     = 16;
	localparam logic [31:0] CONFIG_RESET   = 32'h0000_0101;

	typedef struct packed {
		logic       general_trip_equation;
		logic       direct_transfer_equation;
		logic       assisted_trip_equation;
		logic       echo_conversion_trip;
		logic       switch_onto_trip_equation;
		logic       definite_time_trip;
		logic       phase_time_overcurrent_timed;
		logic [5:0] other_time_overcurrent_timed;
		logic [5:0] frequency_timed;
		logic       residual_ground_trip;
		logic       residual_ground_timing;
		logic       neutral_ground_trip;
	} trip_sources_s;

	typedef struct packed {
		logic       disturbance_detect;
		logic [2:0] phase_involved;
		logic       ground_fault;
		logic       forward_fault;
		logic       phase_c_forward_select;
		logic       phase_b_forward_select;
		logic       phase_a_forward_select;
	} fault_info_s;

	typedef struct packed {
		logic recloser_reset_state;
		logic recloser_cycle_state;
		logic recloser_lockout_state;
	} recloser_state_s;

endpackage

/* src/trip_target_indicator_latch.sv */
// Front-panel trip target indicator latch with APB settings access
`timescale 1ns/100ps
module trip_target_indicator_latch #(
	parameter int unsigned INTERVAL_CYCLES = target_pkg::INTERVAL_CYCLES_DFLT
) (
	// Clock and reset
	input  wire logic                        clk_sys_in,
	input  wire logic                        arst_n_in,
	// APB slave
	input  wire logic                        psel_in,
	input  wire logic                        penable_in,
	input  wire logic                        pwrite_in,
	input  wire logic [7:0]                  paddr_in,
	input  wire logic [31:0]                 pwdata_in,
	output logic [31:0]                      prdata_out,
	output logic                             pready_out,
	output logic                             pslverr_out,
	// Protection logic bits
	input  wire target_pkg::trip_sources_s   sources_in,
	input  wire target_pkg::fault_info_s     fault_in,
	input  wire target_pkg::recloser_state_s recloser_in,
	input  wire logic                        relay_enabled_in,
	input  wire logic                        reset_button_in,
	// Lamps and qualifiers
	output logic [15:0]                      lamps_out,
	output logic                             target_clear_pulse_out,
	output logic                             demand_peak_hold_out,
	output logic                             minmax_block_out,
	output logic                             voltage_base_hold_out
);
	import target_pkg::*;

	localparam int unsigned IW = $clog2(INTERVAL_CYCLES);

	generate
		if (INTERVAL_CYCLES < 2) begin : g_bad_interval
			$error("INTERVAL_CYCLES must be at least 2");
		end
	endgenerate

	// APB state
	logic [31:0] config_reg, config_next;
	logic [31:0] prdata_reg, prdata_next;
	logic        pready_reg, pready_next;
	logic        pslverr_reg, pslverr_next;
	logic        clear_cmd_reg, clear_cmd_next;
	logic        apb_setup, apb_done, mapped, cmd_write;

	// Interval and target state
	logic [IW-1:0]          tick_cnt_reg, tick_cnt_next;
	logic                   tick;
	logic                   trip_prev_reg, trip_prev_next;
	logic                   button_prev_reg, button_prev_next;
	logic [FAULT_AGE_W-1:0] fault_age_reg, fault_age_next;
	logic [LAMP_CNT_W-1:0]  lamp_cnt_reg, lamp_cnt_next;
	logic [12:1]            latched_reg, latched_next;
	logic                   pulse_reg, pulse_next;
	logic [15:0]            lamps_reg, lamps_next;
	logic                   fault_q_reg, fault_q_next;

	logic        trip_now, trip_edge, button_edge, clear_req;
	logic        oc_trip, freq_trip, time_trip, ground_dir, recl_on;
	logic [2:0]  phases;
	logic [12:1] eval;

	assign apb_setup = psel_in && penable_in && !pready_reg;
	assign apb_done  = psel_in && penable_in && pready_reg;
	assign mapped    = (paddr_in == CONFIG_OFS) || (paddr_in == CMD_OFS) ||
		(paddr_in == STATUS_OFS);
	assign cmd_write = apb_done && pwrite_in && (paddr_in == CMD_OFS) &&
		pwdata_in[CMD_CLEAR];

	// APB slave, one wait state
	always_comb begin
		config_next  = config_reg;
		prdata_next  = prdata_reg;
		pready_next  = apb_setup;
		pslverr_next = apb_setup && !mapped;
		if (apb_setup && !pwrite_in) begin
			unique case (paddr_in)
				CONFIG_OFS: prdata_next = config_reg;
				STATUS_OFS: prdata_next = {15'h0000, fault_q_reg, lamps_reg};
				default:    prdata_next = 32'h0000_0000;
			endcase
		end
		if (apb_done && pwrite_in && paddr_in == CONFIG_OFS) begin
			config_next = pwdata_in;
		end
	end

	// Interval tick
	always_comb begin
		tick = (tick_cnt_reg == IW'(INTERVAL_CYCLES - 1));
		tick_cnt_next = tick ? '0 : tick_cnt_reg + IW'(1);
	end

	// Trip and cause evaluation
	always_comb begin
		time_trip   = sources_in.phase_time_overcurrent_timed ||
			(|sources_in.other_time_overcurrent_timed);
		freq_trip   = |sources_in.frequency_timed;
		trip_now = sources_in.general_trip_equation ||
			sources_in.direct_transfer_equation ||
			sources_in.assisted_trip_equation ||
			sources_in.echo_conversion_trip ||
			sources_in.switch_onto_trip_equation ||
			sources_in.definite_time_trip || time_trip ||
			freq_trip || sources_in.residual_ground_trip ||
			sources_in.neutral_ground_trip;
		trip_edge   = tick && trip_now && !trip_prev_reg;
		button_edge = tick && reset_button_in && !button_prev_reg;
		clear_req   = tick && (button_edge || clear_cmd_reg || cmd_write);
		oc_trip     = sources_in.definite_time_trip || time_trip ||
			sources_in.residual_ground_trip ||
			sources_in.neutral_ground_trip;
		ground_dir  = config_reg[CFG_LOW_RATING] && config_reg[CFG_COMP_DIR];
		recl_on     = config_reg[CFG_RECL_EN] &&
			(config_reg[CFG_OI_LSB +: 8] != 8'h00);
		phases = fault_in.phase_involved;
		if (ground_dir && fault_in.ground_fault) begin
			phases = {fault_in.phase_c_forward_select,
				fault_in.phase_b_forward_select,
				fault_in.phase_a_forward_select} &
				{3{fault_in.forward_fault}};
		end
		if ((&phases) && !fault_in.disturbance_detect) begin
			phases = 3'b000;
		end
		eval = '0;
		eval[LAMP_TRIP]    = 1'b1;
		eval[LAMP_INSTANTANEOUS_TRIP_LAMP]    = fault_in.disturbance_detect &&
			(fault_age_reg < FAULT_AGE_W'(FAULT_INSTANTANEOUS_TRIP_LAMP_INTERVALS));
		eval[LAMP_ASSIST]  = sources_in.assisted_trip_equation ||
			sources_in.echo_conversion_trip ||
			sources_in.direct_transfer_equation;
		eval[LAMP_SWITCH]  = sources_in.switch_onto_trip_equation;
		eval[LAMP_DEFTIME] = sources_in.definite_time_trip;
		eval[LAMP_TIMEOC]  = time_trip;
		eval[LAMP_FREQ]    = freq_trip;
		eval[LAMP_PHASE_A +: 3] = oc_trip ? phases : 3'b000;
		eval[LAMP_RESID]   = sources_in.residual_ground_trip ||
			sources_in.residual_ground_timing;
		eval[LAMP_NEUT]    = sources_in.neutral_ground_trip;
		if (!(oc_trip || freq_trip)) begin
			eval[LAMP_INSTANTANEOUS_TRIP_LAMP]          = 1'b0;
			eval[LAMP_SWITCH]        = 1'b0;
			eval[LAMP_DEFTIME +: 8]  = 8'h00;
		end
	end

	// Latching, lamp test, pulse and qualifiers
	always_comb begin
		trip_prev_next   = tick ? trip_now : trip_prev_reg;
		button_prev_next = tick ? reset_button_in : button_prev_reg;
		clear_cmd_next   = (clear_cmd_reg || cmd_write) && !tick;
		fault_age_next   = fault_age_reg;
		if (tick) begin
			if (!fault_in.disturbance_detect) begin
				fault_age_next = '0;
			end else if (fault_age_reg <
				FAULT_AGE_W'(FAULT_INSTANTANEOUS_TRIP_LAMP_INTERVALS)) begin
				fault_age_next = fault_age_reg + FAULT_AGE_W'(1);
			end
		end
		latched_next = latched_reg;
		if (clear_req && !trip_now) begin
			latched_next = '0;
		end
		if (trip_edge) begin
			latched_next = eval;
		end
		pulse_next = tick ? clear_req : pulse_reg;
		lamp_cnt_next = lamp_cnt_reg;
		if (button_edge) begin
			lamp_cnt_next = LAMP_CNT_W'(LAMP_TEST_INTERVALS);
		end else if (tick && lamp_cnt_reg != '0) begin
			lamp_cnt_next = lamp_cnt_reg - LAMP_CNT_W'(1);
		end
		lamps_next = {recloser_in.recloser_lockout_state,
			recloser_in.recloser_cycle_state,
			recloser_in.recloser_reset_state,
			latched_reg, relay_enabled_in};
		if (!recl_on) begin
			lamps_next[LAMP_LO:LAMP_RS] = 3'b000;
		end
		if (lamp_cnt_reg != '0) begin
			lamps_next = 16'hffff;
		end
		fault_q_next = fault_in.disturbance_detect;
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			config_reg      <= CONFIG_RESET;
			prdata_reg      <= 32'h0000_0000;
			pready_reg      <= 1'b0;
			pslverr_reg     <= 1'b0;
			clear_cmd_reg   <= 1'b0;
			tick_cnt_reg    <= '0;
			trip_prev_reg   <= 1'b0;
			button_prev_reg <= 1'b0;
			fault_age_reg   <= '0;
			lamp_cnt_reg    <= '0;
			latched_reg     <= '0;
			pulse_reg       <= 1'b0;
			lamps_reg       <= 16'h0000;
			fault_q_reg     <= 1'b0;
		end else begin
			config_reg      <= config_next;
			prdata_reg      <= prdata_next;
			pready_reg      <= pready_next;
			pslverr_reg     <= pslverr_next;
			clear_cmd_reg   <= clear_cmd_next;
			tick_cnt_reg    <= tick_cnt_next;
			trip_prev_reg   <= trip_prev_next;
			button_prev_reg <= button_prev_next;
			fault_age_reg   <= fault_age_next;
			lamp_cnt_reg    <= lamp_cnt_next;
			latched_reg     <= latched_next;
			pulse_reg       <= pulse_next;
			lamps_reg       <= lamps_next;
			fault_q_reg     <= fault_q_next;
		end
	end

	assign prdata_out             = prdata_reg;
	assign pready_out             = pready_reg;
	assign pslverr_out            = pslverr_reg;
	assign lamps_out              = lamps_reg;
	assign target_clear_pulse_out = pulse_reg;
	assign demand_peak_hold_out   = fault_q_reg;
	assign minmax_block_out       = fault_q_reg;
	assign voltage_base_hold_out  = fault_q_reg;

	// Checks
	property p_trip_lamp;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		trip_edge |=> latched_reg[LAMP_TRIP] ##1 lamps_out[LAMP_TRIP] ||
			lamp_cnt_reg != '0;
	endproperty
	a_trip_lamp: assert property (p_trip_lamp)
		else $error("trip lamp not lit on trip edge");

	property p_no_cause;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		trip_edge && !oc_trip && !freq_trip |=>
			latched_reg[LAMP_NEUT:LAMP_DEFTIME] == 8'h00 &&
			!latched_reg[LAMP_INSTANTANEOUS_TRIP_LAMP] && !latched_reg[LAMP_SWITCH];
	endproperty
	a_no_cause: assert property (p_no_cause)
		else $error("cause lamp lit on plain trip");

	property p_instantaneous_trip_lamp_late;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		trip_edge && fault_age_reg == FAULT_AGE_W'(FAULT_INSTANTANEOUS_TRIP_LAMP_INTERVALS)
			|=> !latched_reg[LAMP_INSTANTANEOUS_TRIP_LAMP];
	endproperty
	a_instantaneous_trip_lamp_late: assert property (p_instantaneous_trip_lamp_late)
		else $error("instantaneous lamp lit after 3 cycles");

	property p_assist;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		trip_edge && sources_in.direct_transfer_equation
			|=> latched_reg[LAMP_ASSIST] && latched_reg[LAMP_TRIP];
	endproperty
	a_assist: assert property (p_assist)
		else $error("assisted lamp missing for direct transfer");

	property p_freq;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		trip_edge |=> latched_reg[LAMP_FREQ] == $past(freq_trip);
	endproperty
	a_freq: assert property (p_freq)
		else $error("frequency lamp wrong");

	property p_recl_off;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		!recl_on && lamp_cnt_reg == '0 |=> lamps_out[LAMP_LO:LAMP_RS] == 3'b000;
	endproperty
	a_recl_off: assert property (p_recl_off)
		else $error("recloser lamp lit while disabled");

	property p_follow;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		recl_on && lamp_cnt_reg == '0 |=>
			lamps_out[LAMP_CY] == $past(recloser_in.recloser_cycle_state);
	endproperty
	a_follow: assert property (p_follow)
		else $error("cycle lamp does not follow recloser");

	property p_lamp_test;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		button_edge |=> ##1 lamps_out == 16'hffff;
	endproperty
	a_lamp_test: assert property (p_lamp_test)
		else $error("lamp test not lighting all lamps");

	property p_clear;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		clear_req && !trip_now |=> latched_reg == '0 ##0 pulse_reg;
	endproperty
	a_clear: assert property (p_clear)
		else $error("target reset did not clear or pulse");

	property p_pulse_end;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		pulse_reg && tick && !clear_req |=> !pulse_reg;
	endproperty
	a_pulse_end: assert property (p_pulse_end)
		else $error("clear pulse longer than one interval");

	property p_qual;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		1'b1 |=> minmax_block_out == $past(fault_in.disturbance_detect) &&
			voltage_base_hold_out == demand_peak_hold_out;
	endproperty
	a_qual: assert property (p_qual)
		else $error("disturbance qualifier not routed");

	property p_deftime;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		trip_edge && sources_in.definite_time_trip
			|=> latched_reg[LAMP_DEFTIME];
	endproperty
	a_deftime: assert property (p_deftime)
		else $error("definite-time lamp missing");

	property p_timeoc;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		trip_edge |=> latched_reg[LAMP_TIMEOC] == $past(time_trip);
	endproperty
	a_timeoc: assert property (p_timeoc)
		else $error("time-overcurrent lamp wrong");

	property p_three_phase;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		trip_edge && !fault_in.disturbance_detect
			|=> latched_reg[LAMP_PHASE_A +: 3] != 3'b111;
	endproperty
	a_three_phase: assert property (p_three_phase)
		else $error("three phases shown without disturbance detect");

	property p_resid;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		trip_edge && oc_trip && (sources_in.residual_ground_trip ||
			sources_in.residual_ground_timing) |=> latched_reg[LAMP_RESID];
	endproperty
	a_resid: assert property (p_resid)
		else $error("residual lamp missing");

	property p_neut;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		trip_edge && sources_in.neutral_ground_trip
			|=> latched_reg[LAMP_NEUT];
	endproperty
	a_neut: assert property (p_neut)
		else $error("neutral lamp missing");

	property p_latch_hold;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		!trip_edge && !clear_req |=> $stable(latched_reg);
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latched lamps changed without trip edge or clear");

endmodule

/* test/panel_side_model.sv */
// Model of the protection logic bits and panel button feeding the latch
`timescale 1ns/100ps
module panel_side_model (
	// Clock
	input  wire logic                   clk_sys_in,
	// Element bits and panel controls
	output target_pkg::trip_sources_s   sources_out,
	output target_pkg::fault_info_s     fault_out,
	output target_pkg::recloser_state_s recloser_out,
	output logic                        relay_enabled_out,
	output logic                        reset_button_out
);
	import target_pkg::*;

	initial begin
		sources_out = '0;
		fault_out = '0;
		recloser_out = '0;
		relay_enabled_out = 1'b1;
		reset_button_out = 1'b0;
	end

	// All element bits change together just after a clock edge
	task automatic drive(input trip_sources_s s, input fault_info_s f,
		input recloser_state_s r, input logic b);
		@(posedge clk_sys_in);
		sources_out <= s;
		fault_out <= f;
		recloser_out <= r;
		reset_button_out <= b;
	endtask
endmodule

/* test/trip_target_indicator_latch_test.sv */
// Self-checking bench for the trip target indicator latch
`timescale 1ns/100ps
module trip_target_indicator_latch_test;
	import target_pkg::*;
	localparam int IC = 4;
	logic            clk_sys_in, arst_n_in, psel, penable, pwrite;
	logic [7:0]      paddr;
	logic [31:0]     pwdata, prdata, rd;
	logic            pready, pslverr, err, pulse, en, btn;
	logic            hold_d, hold_m, hold_v;
	logic [15:0]     lamps;
	trip_sources_s   src;
	fault_info_s     flt;
	recloser_state_s rec, rec_now;
	int              failures, total_checks, pulse_len;

	panel_side_model i_panel_side_model (.clk_sys_in(clk_sys_in),
		.sources_out(src), .fault_out(flt), .recloser_out(rec),
		.relay_enabled_out(en), .reset_button_out(btn));

	trip_target_indicator_latch #(.INTERVAL_CYCLES(IC))
		i_trip_target_indicator_latch (.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.sources_in(src), .fault_in(flt), .recloser_in(rec),
		.relay_enabled_in(en), .reset_button_in(btn), .lamps_out(lamps),
		.target_clear_pulse_out(pulse), .demand_peak_hold_out(hold_d),
		.minmax_block_out(hold_m), .voltage_base_hold_out(hold_v));

	initial begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end

	// Pulse width counter, cleared by the scenarios
	always @(posedge clk_sys_in) begin
		if (pulse === 1'b1)
			pulse_len <= pulse_len + 1;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask

	task automatic iv(input int n);
		repeat (n * IC) @(negedge clk_sys_in);
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_in);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			check(32'h0, 32'h1, "apb answer missing");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic drive(input trip_sources_s s, input fault_info_s f);
		i_panel_side_model.drive(s, f, rec_now, 1'b0);
	endtask

	// Clear, optionally age the disturbance, then trip and judge lamps 1..12
	task automatic trip_case(input trip_sources_s s, input fault_info_s f,
		input int pre, input logic [11:0] exp, input string msg);
		drive('0, '0);
		iv(2);
		apb(1'b1, CMD_OFS, 32'h1);
		iv(3);
		if (pre > 0) begin
			drive('0, f);
			iv(pre);
		end
		drive(s, f);
		iv(3);
		check(32'(lamps[12:1]), 32'(exp), msg);
	endtask

	task automatic clear_case(input logic [11:0] exp);
		pulse_len = 0;
		apb(1'b1, CMD_OFS, 32'h1);
		iv(3);
		check(32'(lamps[12:1]), 32'(exp), "clear result");
		check(pulse_len, IC, "clear pulse width");
	endtask

	task automatic recl_case;
		rec_now = 3'b110;
		drive('0, '0);
		iv(3);
		check(32'(lamps[15:13]), 32'h3, "recloser lamps");
		apb(1'b1, CONFIG_OFS, 32'h0000_0100);
		iv(3);
		check(32'(lamps[15:13]), 32'h0, "recloser off");
		apb(1'b1, CONFIG_OFS, 32'h0000_0001);
		iv(3);
		check(32'(lamps[15:13]), 32'h0, "interval zero");
		apb(1'b1, CONFIG_OFS, CONFIG_RESET);
		iv(3);
		check(32'(lamps[15:13]), 32'h3, "recloser back");
	endtask

	task automatic lamp_case;
		pulse_len = 0;
		i_panel_side_model.drive('0, '0, rec_now, 1'b1);
		iv(2);
		drive('0, '0);
		iv(3);
		check(32'(lamps), 32'hffff, "lamp test on");
		check(pulse_len, IC, "button pulse");
		iv(225);
		check(32'(lamps), 32'hffff, "lamp test held");
		iv(20);
		check(32'(lamps[12:1]), 32'h0, "lamp test over");
	endtask

	task automatic hold_case;
		drive('0, 9'h100);
		iv(1);
		check(32'({hold_d, hold_m, hold_v}), 32'h7, "holds on");
		drive('0, '0);
		iv(1);
		check(32'({hold_d, hold_m, hold_v}), 32'h0, "holds off");
	endtask

	initial begin
		#(30000 * 100);
		failures++;
		$display("[FAIL] %0t watchdog expired", $time);
		wrap_up();
	end

	initial begin
		arst_n_in = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rec_now = '0;
		failures = 0;
		total_checks = 0;
		pulse_len = 0;
		repeat (12) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		apb(1'b0, CONFIG_OFS, 32'h0);
		check(rd, CONFIG_RESET, "config reset value");
		apb(1'b0, 8'h0c, 32'h0);
		check({31'h0, err}, 32'h1, "unmapped error");
		check(rd, 32'h0, "unmapped data");
		apb(1'b0, CMD_OFS, 32'h0);
		check(rd, 32'h0, "command reads zero");
		trip_case(22'h20_0000, 9'h100, 0, 12'h001, "general");
		for (int i = 0; i < 3; i++)
			trip_case(22'h10_0000 >> i, 9'h100, 14, 12'h005, "assist");
		trip_case(22'h01_0000, 9'h160, 0, 12'h193, "fresh");
		trip_case(22'h00_8000, 9'h1e0, 14, 12'h3a1, "aged");
		trip_case(22'h00_8000, 9'h0e0, 0, 12'h021, "no detect");
		trip_case(22'h03_0000, 9'h100, 14, 12'h019, "switch");
		trip_case(22'h01_0002, 9'h100, 14, 12'h411, "residual");
		trip_case(22'h00_0001, 9'h100, 14, 12'h801, "neutral");
		trip_case(22'h00_0100, 9'h100, 14, 12'h041, "freq");
		apb(1'b0, STATUS_OFS, 32'h0);
		check(rd, 32'h0001_0083, "status word");
		clear_case(12'h041);
		apb(1'b1, CONFIG_OFS, 32'h0000_0107);
		apb(1'b0, CONFIG_OFS, 32'h0);
		check(rd, 32'h0000_0107, "config written");
		trip_case(22'h01_0000, 9'h15d, 14, 12'h291, "ground");
		trip_case(22'h01_0000, 9'h155, 14, 12'h011, "reverse");
		apb(1'b1, CONFIG_OFS, CONFIG_RESET);
		drive('0, '0);
		iv(2);
		clear_case(12'h000);
		recl_case();
		lamp_case();
		hold_case();
		wrap_up();
	end
endmodule
